// ==== hw/sensor_mailbox_host_port.sv ====
`timescale 1ns/10ps
// How it works
// - everything runs from one master clock
// - reset pin low past 100 ms resets
// - two LED drivers: on/off, four currents
// - banks 0,1 ready after one period; 2,3 two
// - ready sets flag; interrupt low if enabled
// - control register read releases interrupt
// - any sensor result read clears ready
// - low result byte shadowed after high read
// - continuous modes keep converting, overwrite results
// - bank 3 write runs exactly two conversions
// - slave port active only when selected
// - works at standard and fast rates
// - answers to bus address 0x49 only
// - status bit 1 shows inbound occupied
// - status bit 0 shows outbound byte waiting
// - offset 1 takes address or data bytes
// - offset 2 returns byte to master
// - address top bit: 1 write, 0 read
module sensor_mailbox_host_port #(
   parameter int HOLD_CYCLES = mbx_pkg::RESET_HOLD_CYCLES,
   parameter int STEP_CYCLES = mbx_pkg::IT_STEP_CYCLES,
   parameter logic [15:0] HW_VERSION = 16'h0001, // arbitrary value
   parameter logic [15:0] FW_VERSION = 16'h0001 // arbitrary value
) (
   // clock, reset, enable
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clkEn,
   // device pins
   input wire logic resetLowPin,
   input wire logic hostPortSelect,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // conversion front end
   input wire mbx_pkg::sample_set_t sensorIn,
   // outputs
   output logic irqN,
   output mbx_pkg::led_ctl_t ledCtl
);

   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   if (HOLD_CYCLES < 1 || STEP_CYCLES < 1)
   begin : g_bad_param
      $error("hold and step counts must be at least one");
   end

   localparam int HW = $clog2(HOLD_CYCLES + 1);
   localparam int SW = $clog2(STEP_CYCLES + 1);

   // ------------------------------------------------------------
   // pin synchronisers and pin reset
   // ------------------------------------------------------------
   logic [1:0] sclSync; // [0] first stage only
   logic [1:0] sdaSync;
   logic [1:0] selSync;
   logic [1:0] rstSync;
   logic sclPrev; // delayed second stage
   logic sdaPrev;
   logic [HW-1:0] holdCnt; // low time of reset pin
   logic pinRst; // reset from pin
   logic rst; // combined reset

   // two stages per pin, sampled fast for both bus rates
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         selSync <= 2'h0;
         rstSync <= 2'h3;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end
      else if (clkEn)
      begin
         sclSync <= {sclSync[0], sclIn};
         sdaSync <= {sdaSync[0], sdaIn};
         selSync <= {selSync[0], hostPortSelect};
         rstSync <= {rstSync[0], resetLowPin};
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
      end
   end

   // count low time; reset once it passes the hold figure
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         holdCnt <= '0;
         pinRst <= 1'b0;
      end
      else if (clkEn)
      begin
         if (rstSync[1])
         begin
            holdCnt <= '0;
            pinRst <= 1'b0;
         end
         else if (holdCnt == HW'(HOLD_CYCLES))
            pinRst <= 1'b1;
         else
            holdCnt <= holdCnt + 1'b1;
      end
   end

   assign rst = sys_rst | pinRst;

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   mbx_pkg::i2c_state_t state;
   mbx_pkg::phase_t phase;
   logic [3:0] bitCnt; // bits moved in current byte
   logic [7:0] shiftIn;
   logic [7:0] shiftOut;
   logic rw; // 1 for master read
   logic [1:0] ptr; // physical register pointer
   logic wrStrobe; // byte for inbound register
   logic [7:0] wrByte;
   logic rdStrobe; // outbound register read
   logic [7:0] regByte; // physical register read value
   logic sclRise, sclFall, startCond, stopCond, byteDone;
   logic txValid, rxValid;
   logic [7:0] inbound, outbound;

   assign sclRise = sclSync[1] & ~sclPrev;
   assign sclFall = ~sclSync[1] & sclPrev;
   assign startCond = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
   assign stopCond = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];
   assign byteDone = (state == mbx_pkg::S_RECV) && sclFall
      && (bitCnt == 4'h8);

   // physical register read mux
   always_comb
   begin
      regByte = 8'h00;
      if (ptr == mbx_pkg::REG_FLAGS)
      begin
         regByte[mbx_pkg::TXV_BIT] = txValid;
         regByte[mbx_pkg::RXV_BIT] = rxValid;
      end
      else if (ptr == mbx_pkg::REG_OUTBOUND)
         regByte = outbound;
   end

   // byte-level slave protocol
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= mbx_pkg::S_IDLE;
         phase <= mbx_pkg::PH_ADDR;
         sdaOe <= 1'b0;
         bitCnt <= 4'h0;
         shiftIn <= 8'h00;
         shiftOut <= 8'h00;
         rw <= 1'b0;
         ptr <= 2'h0;
         wrStrobe <= 1'b0;
         wrByte <= 8'h00;
         rdStrobe <= 1'b0;
      end
      else if (clkEn)
      begin
         wrStrobe <= 1'b0;
         rdStrobe <= 1'b0;
         if (!selSync[1])
         begin
            state <= mbx_pkg::S_IDLE;
            sdaOe <= 1'b0;
         end
         else if (startCond)
         begin
            state <= mbx_pkg::S_RECV;
            phase <= mbx_pkg::PH_ADDR;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
         end
         else if (stopCond)
         begin
            state <= mbx_pkg::S_IDLE;
            sdaOe <= 1'b0;
         end
         else
            case (state)
               mbx_pkg::S_RECV:
                  if (sclRise)
                  begin
                     shiftIn <= {shiftIn[6:0], sdaSync[1]};
                     bitCnt <= bitCnt + 4'h1;
                  end
                  else if (byteDone)
                  begin
                     bitCnt <= 4'h0;
                     state <= mbx_pkg::S_ACK;
                     sdaOe <= 1'b1;
                     if (phase == mbx_pkg::PH_ADDR)
                     begin
                        // foreign address: no acknowledge
                        if (shiftIn[7:1] != mbx_pkg::SLAVE_ADDR)
                        begin
                           state <= mbx_pkg::S_IDLE;
                           sdaOe <= 1'b0;
                        end
                        rw <= shiftIn[0];
                     end
                     else if (phase == mbx_pkg::PH_PTR)
                        ptr <= shiftIn[1:0];
                     else if (ptr == mbx_pkg::REG_INBOUND)
                     begin
                        wrStrobe <= 1'b1;
                        wrByte <= shiftIn;
                     end
                  end
               mbx_pkg::S_ACK:
                  if (sclFall)
                  begin
                     if (rw && phase == mbx_pkg::PH_ADDR)
                     begin
                        // first data bit goes out now
                        state <= mbx_pkg::S_SEND;
                        shiftOut <= {regByte[6:0], 1'b0};
                        sdaOe <= ~regByte[7];
                        rdStrobe <= (ptr == mbx_pkg::REG_OUTBOUND);
                        bitCnt <= 4'h1;
                     end
                     else
                     begin
                        state <= mbx_pkg::S_RECV;
                        sdaOe <= 1'b0;
                        phase <= (phase == mbx_pkg::PH_ADDR) ?
                           mbx_pkg::PH_PTR : mbx_pkg::PH_DATA;
                     end
                  end
               mbx_pkg::S_SEND:
                  if (sclFall)
                  begin
                     if (bitCnt == 4'h8)
                     begin
                        sdaOe <= 1'b0;
                        state <= mbx_pkg::S_RACK;
                     end
                     else
                     begin
                        sdaOe <= ~shiftOut[7];
                        shiftOut <= {shiftOut[6:0], 1'b0};
                        bitCnt <= bitCnt + 4'h1;
                     end
                  end
               mbx_pkg::S_RACK:
                  // master nack ends, ack sends another byte
                  if (sclRise)
                     state <= sdaSync[1] ? mbx_pkg::S_IDLE : mbx_pkg::S_ACK;
               default:
                  state <= mbx_pkg::S_IDLE;
            endcase
      end
   end

   // pin only ever pulled low
   always_ff @(posedge clock)
      sdaOut <= 1'b0;

   // ------------------------------------------------------------
   // mailbox and virtual register engine
   // ------------------------------------------------------------
   logic vWrPend; // address taken, data byte due
   logic [6:0] vAddr; // pending write address
   logic consume, isVRead, isVWrite, sensorRead, ctrlRead;
   logic [6:0] sOff; // offset into result bytes
   logic [7:0] vReadData;
   logic [7:0] shadow; // protected low byte
   logic intEn, dataRdy, shotStart;
   logic [1:0] gain;
   logic [7:0] intTime;
   mbx_pkg::bank_t bank;
   logic [15:0] res [0:mbx_pkg::NUM_CH-1];

   // a virtual read waits until the previous answer is taken
   assign consume = txValid & (inbound[7] | vWrPend | ~rxValid);
   assign isVRead = consume & ~vWrPend & ~inbound[7];
   assign isVWrite = consume & vWrPend;
   assign sOff = inbound[6:0] - mbx_pkg::V_SENSOR_FIRST;
   assign sensorRead = isVRead
      && inbound[6:0] >= mbx_pkg::V_SENSOR_FIRST
      && inbound[6:0] <= mbx_pkg::V_SENSOR_LAST;
   assign ctrlRead = isVRead && inbound[6:0] == mbx_pkg::V_CONTROL;
   assign shotStart = isVWrite && vAddr == mbx_pkg::V_CONTROL
      && inbound[mbx_pkg::CTL_BANK_LSB +: 2] == mbx_pkg::BANK_SHOT;

   // virtual register read mux
   always_comb
   begin
      vReadData = 8'h00;
      case (inbound[6:0])
         mbx_pkg::V_HW_HI: vReadData = HW_VERSION[15:8];
         mbx_pkg::V_HW_LO: vReadData = HW_VERSION[7:0];
         mbx_pkg::V_FW_HI: vReadData = FW_VERSION[15:8];
         mbx_pkg::V_FW_LO: vReadData = FW_VERSION[7:0];
         mbx_pkg::V_CONTROL:
         begin
            vReadData[mbx_pkg::CTL_INT_BIT] = intEn;
            vReadData[mbx_pkg::CTL_GAIN_LSB +: 2] = gain;
            vReadData[mbx_pkg::CTL_BANK_LSB +: 2] = bank;
            vReadData[mbx_pkg::CTL_RDY_BIT] = dataRdy;
         end
         mbx_pkg::V_INT_TIME: vReadData = intTime;
         mbx_pkg::V_LED: vReadData = {2'h0, ledCtl};
         default:
            if (sensorRead) // big endian: even offset is high byte
               vReadData = sOff[0] ? shadow : res[sOff[3:1]][15:8];
      endcase
   end

   // physical flags, inbound and outbound bytes
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         txValid <= 1'b0;
         rxValid <= 1'b0;
         inbound <= 8'h00;
         outbound <= 8'h00;
         vWrPend <= 1'b0;
         vAddr <= 7'h00;
      end
      else if (clkEn)
      begin
         if (wrStrobe && !txValid)
         begin
            inbound <= wrByte;
            txValid <= 1'b1;
         end
         else if (consume)
            txValid <= 1'b0;
         if (consume)
         begin
            vWrPend <= ~vWrPend & inbound[7];
            if (!vWrPend)
               vAddr <= inbound[6:0];
         end
         // a new answer wins over a clear in the same cycle
         if (isVRead)
         begin
            rxValid <= 1'b1;
            outbound <= vReadData;
         end
         else if (rdStrobe)
            rxValid <= 1'b0;
      end
   end

   // shadow copy of low result byte
   always_ff @(posedge clock)
   begin
      if (rst)
         shadow <= 8'h00;
      else if (clkEn && sensorRead && !sOff[0])
         shadow <= res[sOff[3:1]][7:0];
   end

   // configuration written through virtual writes
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         intEn <= 1'b0;
         gain <= mbx_pkg::GAIN_RESET;
         bank <= mbx_pkg::BANK_QUAD;
         intTime <= mbx_pkg::INT_TIME_RESET;
         ledCtl <= '0;
      end
      else if (clkEn && isVWrite)
         case (vAddr)
            mbx_pkg::V_CONTROL:
            begin
               intEn <= inbound[mbx_pkg::CTL_INT_BIT];
               gain <= inbound[mbx_pkg::CTL_GAIN_LSB +: 2];
               bank <= mbx_pkg::bank_t'(inbound[mbx_pkg::CTL_BANK_LSB +: 2]);
            end
            mbx_pkg::V_INT_TIME: intTime <= inbound;
            mbx_pkg::V_LED: ledCtl <= inbound[5:0];
            default: ;
         endcase
   end

   // ------------------------------------------------------------
   // conversion timing and results
   // ------------------------------------------------------------
   logic [SW-1:0] stepCnt; // cycles in one step
   logic [7:0] periodCnt; // steps in one period
   logic secondPhase; // second bank of a pair
   logic shotBusy; // one-shot pair in progress
   logic running, twoBank, stepDone, periodEnd, readyEvent;
   logic [5:0] latchMask;

   assign twoBank = bank == mbx_pkg::BANK_ALL || bank == mbx_pkg::BANK_SHOT;
   assign running = bank != mbx_pkg::BANK_SHOT || shotBusy;
   assign stepDone = stepCnt == SW'(STEP_CYCLES - 1);
   // an integration time of zero counts as one step
   assign periodEnd = running && stepDone
      && ({1'b0, periodCnt} + 9'h001) >= {1'b0, intTime};
   assign readyEvent = periodEnd && (!twoBank || secondPhase);

   // which channels latch at this period end
   always_comb
   begin
      latchMask = 6'h00;
      if (periodEnd)
         case (bank)
            mbx_pkg::BANK_QUAD: latchMask = mbx_pkg::MASK_QUAD;
            mbx_pkg::BANK_ALT: latchMask = mbx_pkg::MASK_ALT;
            default: latchMask = secondPhase ?
               mbx_pkg::MASK_SECOND : mbx_pkg::MASK_QUAD;
         endcase
   end

   // integration step and period counters
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         stepCnt <= '0;
         periodCnt <= 8'h00;
         secondPhase <= 1'b0;
         shotBusy <= 1'b0;
      end
      else if (clkEn)
      begin
         if (shotStart)
         begin
            stepCnt <= '0;
            periodCnt <= 8'h00;
            secondPhase <= 1'b0;
            shotBusy <= 1'b1;
         end
         else if (running)
         begin
            if (!stepDone)
               stepCnt <= stepCnt + 1'b1;
            else if (!periodEnd)
            begin
               stepCnt <= '0;
               periodCnt <= periodCnt + 8'h01;
            end
            else
            begin
               stepCnt <= '0;
               periodCnt <= 8'h00;
               secondPhase <= twoBank & ~secondPhase;
               if (bank == mbx_pkg::BANK_SHOT && secondPhase)
                  shotBusy <= 1'b0;
            end
         end
      end
   end

   // result registers, one per channel
   for (genvar ch = 0; ch < mbx_pkg::NUM_CH; ch++)
   begin : g_res
      always_ff @(posedge clock)
      begin
         if (rst)
            res[ch] <= 16'h0000;
         else if (clkEn && latchMask[ch])
            res[ch] <= sensorIn[ch];
      end
   end

   // ready flag and interrupt line; a new event beats a clear
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         dataRdy <= 1'b0;
         irqN <= 1'b1;
      end
      else if (clkEn)
      begin
         if (readyEvent)
            dataRdy <= 1'b1;
         else if (sensorRead)
            dataRdy <= 1'b0;
         if (readyEvent && intEn)
            irqN <= 1'b0;
         else if (ctrlRead)
            irqN <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst || !clkEn);

   a_inbound_kept: assert property (txValid && wrStrobe |=>
      inbound == $past(inbound)) else $error("occupied byte overwritten");
   a_inbound_take: assert property (!txValid && wrStrobe |=>
      txValid && inbound == $past(wrByte)) else $error("byte not taken");
   a_answer_ready: assert property (isVRead |=>
      rxValid && outbound == $past(vReadData)) else $error("no answer");
   a_outbound_clear: assert property (rdStrobe && !isVRead |=>
      !rxValid) else $error("receive flag stuck");
   a_irq_assert: assert property (readyEvent && intEn |=>
      !irqN && dataRdy) else $error("interrupt not raised");
   a_irq_release: assert property (ctrlRead && !readyEvent |=>
      irqN) else $error("interrupt not released");
   a_ready_clear: assert property (sensorRead && !readyEvent |=>
      !dataRdy) else $error("ready not cleared");
   a_shot_stops: assert property (readyEvent && !shotStart && bank ==
      mbx_pkg::BANK_SHOT |=> !shotBusy) else $error("one-shot runs on");
   a_addr_nak: assert property (byteDone && phase ==
      mbx_pkg::PH_ADDR && shiftIn[7:1] != mbx_pkg::SLAVE_ADDR
      && selSync[1] && !startCond && !stopCond |=> state ==
      mbx_pkg::S_IDLE && !sdaOe) else $error("foreign address acked");
   a_port_off: assert property (!selSync[1] |=>
      state == mbx_pkg::S_IDLE && !sdaOe) else $error("port not idle");

   c_vread: cover property (isVRead);
   c_ctrl_write: cover property (isVWrite && vAddr == mbx_pkg::V_CONTROL);
   c_shot_done: cover property (readyEvent && bank == mbx_pkg::BANK_SHOT);
   c_host_read: cover property (rdStrobe);

endmodule

// ==== pkg/mbx_pkg.sv ====
package mbx_pkg;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 100; // system clock rate
   localparam int RESET_HOLD_MS = 100; // pin low time before reset
   localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * 1000 * CLK_MHZ;
   localparam int IT_STEP_US = 2800; // one integration time step
   localparam int IT_STEP_CYCLES = IT_STEP_US * CLK_MHZ;

   // ------------------------------------------------------------
   // physical slave registers
   // ------------------------------------------------------------
   localparam logic [6:0] SLAVE_ADDR = 7'h49; // 7-bit bus address
   localparam logic [1:0] REG_FLAGS = 2'h0; // slave_flags, read-only
   localparam logic [1:0] REG_INBOUND = 2'h1; // inbound_byte, write-only
   localparam logic [1:0] REG_OUTBOUND = 2'h2; // outbound_byte, read-only
   localparam int TXV_BIT = 1; // transmit-valid position
   localparam int RXV_BIT = 0; // receive-valid position

   // ------------------------------------------------------------
   // virtual register map
   // ------------------------------------------------------------
   localparam logic [6:0] V_HW_HI = 7'h00;
   localparam logic [6:0] V_HW_LO = 7'h01;
   localparam logic [6:0] V_FW_HI = 7'h02;
   localparam logic [6:0] V_FW_LO = 7'h03;
   localparam logic [6:0] V_CONTROL = 7'h04;
   localparam logic [6:0] V_INT_TIME = 7'h05;
   localparam logic [6:0] V_LED = 7'h07;
   localparam logic [6:0] V_SENSOR_FIRST = 7'h08; // X high byte
   localparam logic [6:0] V_SENSOR_LAST = 7'h13; // C low byte
   localparam int CTL_INT_BIT = 6; // interrupt enable
   localparam int CTL_GAIN_LSB = 4; // two gain bits
   localparam int CTL_BANK_LSB = 2; // two bank bits
   localparam int CTL_RDY_BIT = 1; // data ready
   localparam logic [7:0] INT_TIME_RESET = 8'h01;
   localparam logic [1:0] GAIN_RESET = 2'h0;

   // ------------------------------------------------------------
   // conversion channels: X, Y, Z, NEAR_INFRARED_RESULT, D, C
   // ------------------------------------------------------------
   localparam int NUM_CH = 6;
   localparam logic [5:0] MASK_QUAD = 6'h0f; // X Y Z NEAR_INFRARED_RESULT
   localparam logic [5:0] MASK_ALT = 6'h33; // X Y D C
   localparam logic [5:0] MASK_SECOND = 6'h30; // D C

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      BANK_QUAD = 2'b00,
      BANK_ALT = 2'b01,
      BANK_ALL = 2'b10,
      BANK_SHOT = 2'b11
   } bank_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RECV = 3'b001,
      S_ACK = 3'b010,
      S_SEND = 3'b011,
      S_RACK = 3'b100
   } i2c_state_t;

   typedef enum logic [1:0] {
      PH_ADDR = 2'b00,
      PH_PTR = 2'b01,
      PH_DATA = 2'b10
   } phase_t;

   // led control byte layout, bit 5 downward
   typedef struct packed {
      logic [1:0] mainCurrent; // 12.5, 25, 50, 100 mA
      logic mainOn;
      logic [1:0] indCurrent; // 1, 2, 4, 8 mA
      logic indOn;
   } led_ctl_t;

   typedef logic [NUM_CH-1:0][15:0] sample_set_t;

endpackage

// ==== verif/i2c_master_model.sv ====
`timescale 1ns/10ps
// bus master on the slave's far side, open drain with pull-up
module i2c_master_model #(parameter int HALF = 10) (
   // clock
   input wire logic clock,
   // bus lines
   input wire logic sdaOe,
   output logic scl,
   output logic sda
);
   logic pullLow; // master pulls data low
   assign sda = !(pullLow || sdaOe); // wired-and, pull-up when released
   initial
   begin
      scl = 1'b1;
      pullLow = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // one bit: data set while clock low, sampled mid high
   task automatic bit_io(input logic b, output logic seen);
      pullLow = !b;
      tick(HALF);
      scl = 1'b1;
      tick(HALF / 2);
      seen = sda;
      tick(HALF / 2);
      scl = 1'b0;
   endtask
   task automatic start();
      pullLow = 1'b0;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      pullLow = 1'b1;
      tick(HALF);
      scl = 1'b0;
   endtask
   task automatic stop();
      pullLow = 1'b1;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      pullLow = 1'b0;
      tick(HALF);
   endtask
   // byte msb first, ninth bit released; reads end with a nack
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], s);
         q[i] = s;
      end
      bit_io(1'b1, s);
      ack = !s;
   endtask
   task automatic reg_write(input logic [7:0] adr, input logic [1:0] ptr,
                            input logic [7:0] d, output logic ack);
      logic [7:0] q;
      logic a1, a2, a3;
      start();
      xfer(adr, q, a1);
      xfer({6'h00, ptr}, q, a2);
      xfer(d, q, a3);
      stop();
      ack = a1 && a2 && a3;
   endtask
   task automatic reg_read(input logic [1:0] ptr, output logic [7:0] d);
      logic [7:0] q;
      logic a;
      start();
      xfer(8'h92, q, a);
      xfer({6'h00, ptr}, q, a);
      start();
      xfer(8'h93, q, a);
      xfer(8'hff, d, a);
      stop();
   endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   logic clock, sys_rst, hostPortSelect, scl, sda, sdaOut, sdaOe, irqN, ack;
   logic clkEn, resetLowPin;
   mbx_pkg::sample_set_t sensorIn;
   mbx_pkg::led_ctl_t ledCtl;
   int fails = 0, tests_run = 0, cycles = 0;
   int vexp [int]; // behavioural virtual map
   logic [15:0] seed;
   logic [7:0] q;
   sensor_mailbox_host_port #(.HOLD_CYCLES(20), .STEP_CYCLES(10)) DUT (
      .clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
      .resetLowPin(resetLowPin),
      .hostPortSelect(hostPortSelect), .sclIn(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .sensorIn(sensorIn), .irqN(irqN),
      .ledCtl(ledCtl));
   i2c_master_model #(.HALF(10)) master (.clock(clock), .sdaOe(sdaOe),
      .scl(scl), .sda(sda));
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // next state of the 16-bit stimulus register
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // sixteen steps per channel so every sample gets fresh bits
   task automatic shuffle();
      for (int i = 0; i < 6; i++)
      begin
         repeat (16) seed = lfsr_next(seed);
         sensorIn[i] = seed;
      end
   endtask
   // poll status until bit b reads v
   task automatic poll(input int b, input logic v);
      int n = 0;
      do
      begin
         master.reg_read(2'h0, q);
         n++;
      end while (q[b] !== v && n < 20);
      check("status poll", q[b], v);
   endtask
   task automatic wr(input logic [7:0] d);
      master.reg_write(8'h92, 2'h1, d, ack);
      check("ack", ack, 1'b1);
   endtask
   task automatic vwrite(input logic [6:0] a, input logic [7:0] d);
      poll(1, 1'b0);
      wr({1'b1, a});
      poll(1, 1'b0);
      wr(d);
      vexp[a] = d;
   endtask
   task automatic vread(input logic [6:0] a);
      poll(1, 1'b0);
      wr({1'b0, a});
      poll(0, 1'b1);
      master.reg_read(2'h2, q);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      sys_rst = 1'b1;
      clkEn = 1'b1;
      resetLowPin = 1'b1;
      hostPortSelect = 1'b1;
      seed = 16'h0011;
      shuffle();
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      check("irq idle", irqN, 1'b1);
      check("led reset", ledCtl, 6'h00);
      check("sda out", sdaOut, 1'b0);
      master.reg_read(2'h0, q);
      check("status reset", q, 8'h00);
      master.reg_write(8'ha4, 2'h1, 8'h00, ack);
      check("foreign address", ack, 1'b0);
      hostPortSelect = 1'b0;
      master.reg_write(8'h92, 2'h1, 8'h00, ack);
      check("port off", ack, 1'b0);
      hostPortSelect = 1'b1;
      $display("test reset and addressing done");
      vwrite(7'h07, seed[7:0]);
      check("led pins", ledCtl, vexp[7][5:0]);
      vread(7'h07);
      check("led readback", q, vexp[7] & 8'h3f);
      vread(7'h00);
      check("hw version", q, 8'h00);
      $display("test led and version done");
      // pin held low: state kept after 10 cycles, reset after 30
      resetLowPin = 1'b0;
      master.tick(10);
      check("short pin low", ledCtl, vexp[7][5:0]);
      master.tick(20);
      check("pin reset", ledCtl, 6'h00);
      resetLowPin = 1'b1;
      master.tick(5);
      $display("test pin reset done");
      vwrite(7'h04, 8'h4c);
      master.tick(60);
      check("one shot irq", irqN, 1'b0);
      vread(7'h04);
      check("ready set", q, vexp[4] | 2);
      check("irq released", irqN, 1'b1);
      vread(7'h08);
      check("x high", q, sensorIn[0][15:8]);
      vread(7'h09);
      check("x low", q, sensorIn[0][7:0]);
      vread(7'h04);
      check("ready cleared", q, vexp[4]);
      $display("test one shot done");
      // banks 0, 1, 2: read Y, then D, then C after fresh samples
      for (int m = 0; m < 3; m++)
      begin
         int ch;
         ch = (m == 0) ? 1 : m + 3;
         vwrite(7'h04, 8'h40 | 8'(m << 2));
         shuffle();
         master.tick(60);
         check("continuous irq", irqN, 1'b0);
         vread(7'(8 + 2 * ch));
         check("fresh result", q, sensorIn[ch][15:8]);
      end
      $display("test continuous done");
      // frozen block must not answer the bus
      clkEn = 1'b0;
      master.reg_write(8'h92, 2'h1, 8'h00, ack);
      check("frozen port", ack, 1'b0);
      clkEn = 1'b1;
      $display("test clock enable done");
      tally_and_finish();
   end
endmodule
